// ==== verilog/adc_core_timing_trigger_ctrl.sv ====
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module adc_core_timing_trigger_ctrl (
  input wire logic clock, // 10 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [3:0] addr, // Register index
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data, cycle after rd
  input wire logic [25:0] trig_in, // Channel trigger sources
  input wire logic [25:0] ext_early, // Early events from other cores
  input wire logic [25:0] buf_read, // Result buffer read pulses
  output logic [25:0] chan_trig, // Qualified channel triggers
  output logic [1:0] core_tick, // Core clock enable pulses
  output logic [1:0] converting, // Core in conversion
  output logic [1:0] data_ready, // Conversion done pulse
  output logic [1:0] early_pulse, // Core early event pulse
  output logic [25:0] early_flag, // Early status flags
  output logic irq // Level interrupt
);
  adc_timing_pkg::state_t q;
  adc_timing_pkg::state_t next_q;

  // Core clock period in source periods, divider 0 and 1 both give two
  function automatic logic [7:0] core_period(input logic [6:0] div);
    core_period = (div < 7'h02) ? adc_timing_pkg::MIN_PERIOD : {div, 1'b0};
  endfunction : core_period

  // Conversion length for a resolution code
  function automatic logic [10:0] res_len(input logic [1:0] res);
    unique case (res)
      adc_timing_pkg::RES_12: res_len = adc_timing_pkg::LEN_12;
      adc_timing_pkg::RES_10: res_len = adc_timing_pkg::LEN_10;
      adc_timing_pkg::RES_8: res_len = adc_timing_pkg::LEN_8;
      default: res_len = adc_timing_pkg::LEN_6;
    endcase
  endfunction : res_len

  // Control word as stored, bit 7 is unimplemented and always reads zero
  function automatic logic [12:0] ctl_word(input logic [15:0] d);
    ctl_word = {d[adc_timing_pkg::CTL_W-1:adc_timing_pkg::RES_LSB], 1'b0,
                d[adc_timing_pkg::DIV_W-1:0]};
  endfunction : ctl_word

  // Next state of the whole block
  always_comb begin
    logic [25:0] ev;
    logic [3:0] iev;
    logic [2:0] lead;
    ev = '0;
    iev = '0;
    lead = '0;
    next_q = q;
    next_q.rdata = adc_timing_pkg::RST_ZERO;
    next_q.ready = '0;
    next_q.early = '0;
    next_q.ctick = '0;
    next_q.src_tick = 1'b0;
    // Register writes, upper unimplemented bits dropped
    if (wr) begin
      unique case (addr)
        adc_timing_pkg::A_DELAY0: next_q.dly[0] = wdata[adc_timing_pkg::DLY_W-1:0];
        adc_timing_pkg::A_DELAY1: next_q.dly[1] = wdata[adc_timing_pkg::DLY_W-1:0];
        adc_timing_pkg::A_CTRL0: next_q.ctl[0] = ctl_word(wdata);
        adc_timing_pkg::A_CTRL1: next_q.ctl[1] = ctl_word(wdata);
        adc_timing_pkg::A_LVL_LO: next_q.lvl[15:0] = wdata;
        adc_timing_pkg::A_LVL_HI: next_q.lvl[25:16] = wdata[adc_timing_pkg::CH_HI_W-1:0];
        adc_timing_pkg::A_ALLOW_LO: next_q.allow[15:0] = wdata;
        adc_timing_pkg::A_ALLOW_HI: next_q.allow[25:16] = wdata[adc_timing_pkg::CH_HI_W-1:0];
        adc_timing_pkg::A_FLAG_LO: next_q.eflag[15:0] = wdata;
        adc_timing_pkg::A_FLAG_HI: next_q.eflag[25:16] = wdata[adc_timing_pkg::CH_HI_W-1:0];
        adc_timing_pkg::A_COMMON: begin
          next_q.srcdiv = wdata[adc_timing_pkg::SRCDIV_LSB+:adc_timing_pkg::SRCDIV_W];
          next_q.ext_on = wdata[1:0];
        end
        adc_timing_pkg::A_IRQ_STAT: next_q.ist = q.ist & ~wdata[3:0];
        adc_timing_pkg::A_IRQ_MASK: next_q.imask = wdata[3:0];
        default: ;
      endcase
    end
    // Register reads, answered one cycle later
    if (rd) begin
      unique case (addr)
        adc_timing_pkg::A_DELAY0: next_q.rdata = {6'h00, q.dly[0]};
        adc_timing_pkg::A_DELAY1: next_q.rdata = {6'h00, q.dly[1]};
        adc_timing_pkg::A_CTRL0: next_q.rdata = {3'h0, q.ctl[0]};
        adc_timing_pkg::A_CTRL1: next_q.rdata = {3'h0, q.ctl[1]};
        adc_timing_pkg::A_LVL_LO: next_q.rdata = q.lvl[15:0];
        adc_timing_pkg::A_LVL_HI: next_q.rdata = {6'h00, q.lvl[25:16]};
        adc_timing_pkg::A_ALLOW_LO: next_q.rdata = q.allow[15:0];
        adc_timing_pkg::A_ALLOW_HI: next_q.rdata = {6'h00, q.allow[25:16]};
        adc_timing_pkg::A_FLAG_LO: next_q.rdata = q.eflag[15:0];
        adc_timing_pkg::A_FLAG_HI: next_q.rdata = {6'h00, q.eflag[25:16]};
        adc_timing_pkg::A_COMMON: next_q.rdata = {2'h0, q.srcdiv, 6'h00, q.ext_on};
        adc_timing_pkg::A_STATUS: next_q.rdata = {10'h000, q.pend, q.conv, ~q.conv};
        adc_timing_pkg::A_IRQ_STAT: next_q.rdata = {12'h000, q.ist};
        adc_timing_pkg::A_IRQ_MASK: next_q.rdata = {12'h000, q.imask};
        default: next_q.rdata = adc_timing_pkg::RST_ZERO;
      endcase
    end
    // Core source clock enable from the common divider
    if (q.src_cnt >= q.srcdiv) begin
      next_q.src_cnt = '0;
      next_q.src_tick = 1'b1;
    end else begin
      next_q.src_cnt = q.src_cnt + 6'h01;
    end
    // Trigger sensitivity per channel
    next_q.trig_prev = trig_in;
    next_q.chan_trig = (q.lvl & trig_in) | (~q.lvl & trig_in & ~q.trig_prev);
    // Per core clock divider and conversion sequencer
    for (int c = 0; c < 2; c++) begin
      if (q.src_tick) begin
        if (q.ccnt[c] >= core_period(q.ctl[c][adc_timing_pkg::DIV_W-1:0]) - 8'h01) begin
          next_q.ccnt[c] = '0;
          next_q.ctick[c] = 1'b1;
        end else begin
          next_q.ccnt[c] = q.ccnt[c] + 8'h01;
        end
      end
      lead = q.ctl[c][adc_timing_pkg::LEAD_LSB+:3];
      if (q.st[c] == adc_timing_pkg::S_IDLE && q.chan_trig[c]) begin
        next_q.pend[c] = 1'b1;
      end
      if (q.ctick[c]) begin
        unique case (q.st[c])
          adc_timing_pkg::S_IDLE: begin
            if (q.pend[c]) begin
              next_q.pend[c] = 1'b0;
              if (q.ext_on[c]) begin
                next_q.st[c] = adc_timing_pkg::S_DELAY;
                next_q.cnt[c] = {1'b0, q.dly[c]} + adc_timing_pkg::DLY_EXTRA;
              end else begin
                next_q.st[c] = adc_timing_pkg::S_CONV;
                next_q.conv[c] = 1'b1;
                next_q.cnt[c] = res_len(q.ctl[c][adc_timing_pkg::RES_LSB+:2]);
              end
            end
          end
          adc_timing_pkg::S_DELAY: begin
            if (q.cnt[c] <= 11'h001) begin
              next_q.st[c] = adc_timing_pkg::S_CONV;
              next_q.conv[c] = 1'b1;
              next_q.cnt[c] = res_len(q.ctl[c][adc_timing_pkg::RES_LSB+:2]);
            end else begin
              next_q.cnt[c] = q.cnt[c] - 11'h001;
            end
          end
          adc_timing_pkg::S_CONV: begin
            // Early point counted in core periods before ready
            if (q.cnt[c] == {8'h00, lead} + adc_timing_pkg::EARLY_OFS) begin
              next_q.early[c] = 1'b1;
            end
            if (q.cnt[c] <= 11'h001) begin
              next_q.st[c] = adc_timing_pkg::S_IDLE;
              next_q.conv[c] = 1'b0;
              next_q.ready[c] = 1'b1;
            end else begin
              next_q.cnt[c] = q.cnt[c] - 11'h001;
            end
          end
          default: next_q.st[c] = adc_timing_pkg::S_IDLE;
        endcase
      end
    end
    // Early status: buffer read clears, a new event wins
    ev = ext_early | {24'h000000, q.early};
    next_q.eflag = (next_q.eflag & ~buf_read) | (ev & q.allow);
    // Sticky interrupt status, set wins over write-one clear
    iev = {q.ready, q.early};
    next_q.ist = next_q.ist | iev;
    next_q.irq = |(next_q.ist & q.imask);
  end

  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: {adc_timing_pkg::S_IDLE, adc_timing_pkg::S_IDLE}, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign rdata = q.rdata;
  assign chan_trig = q.chan_trig;
  assign core_tick = q.ctick;
  assign converting = q.conv;
  assign data_ready = q.ready;
  assign early_pulse = q.early;
  assign early_flag = q.eflag;
  assign irq = q.irq;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Checks on the core sequencers
  for (genvar c = 0; c < 2; c++) begin : g_chk
    a_delay_load: assert property (
      q.st[c] == adc_timing_pkg::S_IDLE && q.pend[c] && q.ctick[c] && q.ext_on[c]
      |=> q.cnt[c] == {1'b0, $past(q.dly[c])} + 11'h001)
      else $error("delay count not loaded");
    a_delay_sample: assert property (
      q.st[c] == adc_timing_pkg::S_IDLE && q.pend[c] && q.ctick[c] && q.ext_on[c]
      |=> q.st[c] == adc_timing_pkg::S_DELAY && !converting[c])
      else $error("delay did not keep sampling");
    a_direct_start: assert property (
      q.st[c] == adc_timing_pkg::S_IDLE && q.pend[c] && q.ctick[c] && !q.ext_on[c]
      |=> converting[c])
      else $error("conversion did not start");
    a_early_lead: assert property (
      early_pulse[c]
      |-> !data_ready[c] &&
        q.cnt[c] == {8'h00, $past(q.ctl[c][adc_timing_pkg::LEAD_LSB+:3])} + 11'h001)
      else $error("early pulse lead wrong");
    a_res_len: assert property (
      $rose(converting[c]) && q.ctl[c][adc_timing_pkg::RES_LSB+:2] == 2'h3
      |-> q.cnt[c] == 11'h00C)
      else $error("wrong conversion length");
    a_core_tick: assert property (
      core_tick[c] |-> $past(q.src_tick))
      else $error("core tick without source tick");
    // Sequencer pulses only on core ticks, no conversion while delaying, no trigger taken while busy
    a_delay_quiet: assert property (
      q.st[c] == adc_timing_pkg::S_DELAY
      |-> !converting[c])
      else $error("converting during delay");
    a_early_tick: assert property (
      early_pulse[c]
      |-> $past(q.ctick[c]))
      else $error("early pulse off the core clock");
    a_ready_tick: assert property (
      data_ready[c]
      |-> $past(q.ctick[c]) && !converting[c])
      else $error("ready pulse off the core clock");
    a_busy_refuse: assert property (
      q.st[c] != adc_timing_pkg::S_IDLE && !q.pend[c]
      |=> !q.pend[c])
      else $error("trigger taken while busy");
  end

  a_src_div: assert property (
    q.src_tick |-> q.src_cnt == 6'h00 || q.srcdiv == 6'h00)
    else $error("source divider misaligned");
  a_flag_clear: assert property (
    buf_read[0] && !ext_early[0] && !early_pulse[0] |=> !early_flag[0])
    else $error("buffer read did not clear flag");
  a_flag_set: assert property (
    ext_early[20] && q.allow[20] |=> early_flag[20])
    else $error("allowed early event lost");
  a_unimpl_zero: assert property (
    rd && addr == adc_timing_pkg::A_CTRL0 |=> rdata[15:13] == 3'h0 && !rdata[7])
    else $error("unimplemented bits not zero");

  // Trigger qualification, flag keeping, the register port and the interrupt level
  a_level_trig: assert property (
    q.lvl[1] && trig_in[1]
    |=> chan_trig[1])
    else $error("level trigger not passed");
  a_edge_once: assert property (
    !q.lvl[2] && q.trig_prev[2]
    |=> !chan_trig[2])
    else $error("edge trigger repeated on held level");
  a_flag_block: assert property (
    early_pulse[0] && !q.allow[0] && !ext_early[0] && !early_flag[0] && !wr
    |=> !early_flag[0])
    else $error("blocked early event set flag");
  a_flag_sticky: assert property (
    early_flag[0] && !buf_read[0] && !wr
    |=> early_flag[0])
    else $error("early flag lost without buffer read");
  a_ctl_gap: assert property (
    wr && addr == adc_timing_pkg::A_CTRL0
    |=> !q.ctl[0][7])
    else $error("unimplemented control bit stored");
  a_rdata_idle: assert property (
    !$past(rd)
    |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_irq_level: assert property (
    1'b1
    |=> irq == |(q.ist & $past(q.imask)))
    else $error("interrupt level wrong");
endmodule : adc_core_timing_trigger_ctrl

// ==== verilog/adc_timing_pkg.sv ====
package adc_timing_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] A_DELAY0 = 4'h0;
  localparam logic [3:0] A_DELAY1 = 4'h1;
  localparam logic [3:0] A_CTRL0 = 4'h2;
  localparam logic [3:0] A_CTRL1 = 4'h3;
  localparam logic [3:0] A_LVL_LO = 4'h4;
  localparam logic [3:0] A_LVL_HI = 4'h5;
  localparam logic [3:0] A_ALLOW_LO = 4'h6;
  localparam logic [3:0] A_ALLOW_HI = 4'h7;
  localparam logic [3:0] A_FLAG_LO = 4'h8;
  localparam logic [3:0] A_FLAG_HI = 4'h9;
  localparam logic [3:0] A_COMMON = 4'hA;
  localparam logic [3:0] A_STATUS = 4'hB;
  localparam logic [3:0] A_IRQ_STAT = 4'hC;
  localparam logic [3:0] A_IRQ_MASK = 4'hD;
  // Field layout
  localparam int DLY_W = 10;
  localparam int CTL_W = 13;
  localparam int LEAD_LSB = 10;
  localparam int RES_LSB = 8;
  localparam int DIV_W = 7;
  localparam int SRCDIV_LSB = 8;
  localparam int SRCDIV_W = 6;
  localparam int HALF = 16;
  localparam int CH_HI_W = 10;
  localparam int CNT_W = 11;
  localparam int CCNT_W = 8;
  // Delay offset in core clock periods beyond the programmed count
  localparam logic [CNT_W-1:0] DLY_EXTRA = 11'h001;
  // Remaining count at the early tick beyond the lead field
  localparam logic [CNT_W-1:0] EARLY_OFS = 11'h002;
  // Conversion lengths in core clock periods per resolution code
  localparam logic [CNT_W-1:0] LEN_12 = 11'h00C;
  localparam logic [CNT_W-1:0] LEN_10 = 11'h00A;
  localparam logic [CNT_W-1:0] LEN_8 = 11'h008;
  localparam logic [CNT_W-1:0] LEN_6 = 11'h006;
  localparam logic [1:0] RES_12 = 2'h3;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [CCNT_W-1:0] MIN_PERIOD = 8'h02;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DELAY = 3'b010,
    S_CONV = 3'b100
  } core_state_t;

  typedef struct packed {
    logic [1:0][DLY_W-1:0] dly;
    logic [1:0][CTL_W-1:0] ctl;
    logic [SRCDIV_W-1:0] srcdiv;
    logic [1:0] ext_on;
    logic [25:0] lvl;
    logic [25:0] allow;
    logic [25:0] eflag;
    logic [3:0] ist;
    logic [3:0] imask;
    logic [SRCDIV_W-1:0] src_cnt;
    logic src_tick;
    logic [1:0][CCNT_W-1:0] ccnt;
    logic [1:0] ctick;
    logic [25:0] trig_prev;
    logic [25:0] chan_trig;
    logic [1:0] pend;
    core_state_t [1:0] st;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0] conv;
    logic [1:0] ready;
    logic [1:0] early;
    logic [15:0] rdata;
    logic irq;
  } state_t;
endpackage : adc_timing_pkg

// ==== verification/conv_side_model.sv ====
`timescale 1ns/1ps
// Stand-in for trigger sources, other cores and result buffer readers
module conv_side_model (
  input wire logic clock, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [25:0] hold_trig, // Requested trigger levels
  input wire logic [25:0] early_req, // Requested early events
  input wire logic [25:0] read_req, // Requested buffer reads
  output logic [25:0] trig_in, // Trigger sources
  output logic [25:0] ext_early, // Early event pulses
  output logic [25:0] buf_read // Buffer read pulses
);
  // Launch each request on the edge after it is asked for
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trig_in <= 26'h0000000;
      ext_early <= 26'h0000000;
      buf_read <= 26'h0000000;
    end else begin
      trig_in <= hold_trig;
      ext_early <= early_req;
      buf_read <= read_req;
    end
  end
endmodule : conv_side_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clock, nrst, wr, rd, irq, rd_d, early_seen;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [25:0] trig_in, ext_early, buf_read, chan_trig, early_flag, hold_trig, early_req, read_req;
  logic [1:0] core_tick, converting, data_ready, early_pulse;
  logic [1:0] ph = 2'h0;
  logic [23:0] ce;
  logic [15:0] rq[$];
  logic [23:0] cq[$];
  int mismatches = 0, checks = 0, dcnt, ccnt, ecnt, gap = 0, per_exp, lvl_cnt = 0, edge_cnt = 0;
  int lead, rdy1_cnt = 0, ear1_cnt = 0;

  conv_side_model conv_side_model_inst (.clock(clock), .nrst(nrst), .hold_trig(hold_trig),
    .early_req(early_req), .read_req(read_req), .trig_in(trig_in), .ext_early(ext_early),
    .buf_read(buf_read));
  adc_core_timing_trigger_ctrl adc_core_timing_trigger_ctrl_inst (.clock(clock), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in),
    .ext_early(ext_early), .buf_read(buf_read), .chan_trig(chan_trig), .core_tick(core_tick),
    .converting(converting), .data_ready(data_ready), .early_pulse(early_pulse),
    .early_flag(early_flag), .irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("Mismatches %0d, checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // One-cycle strobes; a spare edge between calls keeps each strobe single-driven
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg

  // Configure core 0, fire one edge trigger on channel 0, wait for the result
  task automatic run_conv(input logic [1:0] res, input int ld, input int div, input int src,
                          input logic dlyon, input int dly);
    int t;
    per_exp = (src + 1) * 2 * ((div > 1) ? div : 1);
    cq.push_back({(dlyon ? 12'(dly + 2) : 12'h001), 8'(6 + 2 * res), 4'(ld + 1)});
    wr_reg(adc_timing_pkg::A_CTRL0, 16'({3'(ld), res, 1'b0, 7'(div)}));
    wr_reg(adc_timing_pkg::A_COMMON, 16'({6'(src), 7'h00, dlyon}));
    wr_reg(adc_timing_pkg::A_DELAY0, 16'(dly));
    @(posedge clock) hold_trig[0] <= 1'b1;
    @(posedge clock) hold_trig[0] <= 1'b0;
    for (t = 0; t < 5000 && data_ready[0] !== 1'b1; t++) @(posedge clock);
    if (t == 5000) begin
      mismatches++;
      summarize();
    end
    repeat (2) @(posedge clock);
  endtask : run_conv

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Result watcher: read data and core 0 timing against the oldest note
  always @(posedge clock) begin
    rd_d <= rd;
    gap <= core_tick[0] ? 1 : gap + 1;
    lvl_cnt <= lvl_cnt + int'(chan_trig[1]);
    edge_cnt <= edge_cnt + int'(chan_trig[2]);
    rdy1_cnt <= rdy1_cnt + int'(data_ready[1]);
    ear1_cnt <= ear1_cnt + int'(early_pulse[1]);
    if (rd_d) check({16'h0000, rdata}, {16'h0000, rq.pop_front()});
    if (nrst && ph == 2'h0 && chan_trig[0] && !converting[0]) begin
      ph <= 2'h1;
      dcnt <= 0;
    end else if (ph == 2'h1 && converting[0]) begin
      ce = cq.pop_front();
      check(dcnt, ce[23:12]);
      ph <= 2'h2;
      ccnt <= int'(core_tick[0]);
      ecnt <= 0;
      early_seen <= 1'b0;
    end else if (ph == 2'h1) begin
      dcnt <= dcnt + int'(core_tick[0]);
    end else if (ph == 2'h2) begin
      if (core_tick[0] && ccnt > 0) check(gap, per_exp);
      ccnt <= ccnt + int'(core_tick[0]);
      if (early_pulse[0]) early_seen <= 1'b1;
      if ((early_seen || early_pulse[0]) && core_tick[0]) ecnt <= ecnt + 1;
      if (data_ready[0]) begin
        check(ccnt, ce[11:4]);
        check(ecnt, ce[3:0]);
        check(early_seen | early_pulse[0], 1);
        ph <= 2'h0;
      end
    end
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    hold_trig = 26'h0000000;
    early_req = 26'h0000000;
    read_req = 26'h0000000;
    void'($urandom(32'h0d21));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    wr_reg(adc_timing_pkg::A_DELAY0, 16'hFFFF);
    wr_reg(adc_timing_pkg::A_CTRL0, 16'hFFFF);
    wr_reg(adc_timing_pkg::A_LVL_HI, 16'hFFFF);
    rd_reg(adc_timing_pkg::A_DELAY0, 16'h03FF);
    rd_reg(adc_timing_pkg::A_CTRL0, 16'h1F7F);
    rd_reg(adc_timing_pkg::A_LVL_HI, 16'h03FF);
    rd_reg(4'hE, 16'h0000);
    wr_reg(adc_timing_pkg::A_LVL_HI, 16'h0000);
    wr_reg(adc_timing_pkg::A_ALLOW_LO, 16'h0001);
    // Every resolution, valid lead only, random dividers
    for (int r = 0; r < 4; r++) begin
      lead = $urandom % ((r == 0) ? 4 : ((r == 1) ? 6 : 8));
      run_conv(2'(r), lead, $urandom % 4, $urandom % 3, 1'b0, 0);
    end
    #1 check(irq, 1'b0);
    wr_reg(adc_timing_pkg::A_IRQ_MASK, 16'h0004);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b1);
    wr_reg(adc_timing_pkg::A_IRQ_STAT, 16'h0004);
    repeat (2) @(posedge clock);
    #1 check(irq, 1'b0);
    rd_reg(adc_timing_pkg::A_FLAG_LO, 16'h0001);
    @(posedge clock) read_req[0] <= 1'b1;
    @(posedge clock) read_req[0] <= 1'b0;
    rd_reg(adc_timing_pkg::A_FLAG_LO, 16'h0000);
    wr_reg(adc_timing_pkg::A_ALLOW_LO, 16'h0000);
    run_conv(2'h3, 0, 1, 0, 1'b0, 0);
    rd_reg(adc_timing_pkg::A_FLAG_LO, 16'h0000);
    run_conv(2'h2, 1, 1, 0, 1'b1, $urandom % 6);
    run_conv(2'h1, 2, 2, 1, 1'b1, 0);
    wr_reg(adc_timing_pkg::A_ALLOW_HI, 16'h0010);
    @(posedge clock) early_req[20] <= 1'b1;
    @(posedge clock) early_req[20] <= 1'b0;
    rd_reg(adc_timing_pkg::A_FLAG_HI, 16'h0010);
    check(early_flag, 26'h0100000);
    // Channel 1 level-sensitive, channel 2 edge-sensitive, both held three cycles
    wr_reg(adc_timing_pkg::A_LVL_LO, 16'h0002);
    @(posedge clock) hold_trig[2:1] <= 2'b11;
    repeat (3) @(posedge clock);
    hold_trig[2:1] <= 2'b00;
    repeat (4) @(posedge clock);
    check(lvl_cnt, 3);
    check(edge_cnt, 1);
    // Channel 1 level trigger runs one direct conversion on core 1
    for (int t = 0; t < 300 && rdy1_cnt == 0; t++) @(posedge clock);
    repeat (4) @(posedge clock);
    check(rdy1_cnt, 1);
    check(ear1_cnt, 1);
    summarize();
  end
endmodule : tb_top
